// file: pkg/scr_pkg.sv
// constants for the system configuration register block
package scr_pkg;
  // clock and timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned HALF_PERIOD_NS = CLK_PERIOD_NS / 2;
  localparam int unsigned RST_DRIVE_HALVES = 1024;
  localparam int unsigned RST_DRIVE_CYCLES =
      (RST_DRIVE_HALVES * HALF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OSC_WD_TIMEOUT_NS = 1000;
  localparam int unsigned OSC_WD_CYCLES =
      (OSC_WD_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CS_LATCH_HALVES = 1;
  localparam int unsigned CS_LATCH_CYCLES_RAW =
      (CS_LATCH_HALVES * HALF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CS_LATCH_CYCLES = (CS_LATCH_CYCLES_RAW < 1) ? 1 : CS_LATCH_CYCLES_RAW;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_SYS_CONFIG = 16'hFF12;
  localparam logic [15:0] IDX_BITMOD = 16'hFF13;
  localparam logic [15:0] IDX_CMD = 16'hFF14;
  localparam logic [7:0] BIT_ADDR_SYS_CONFIG = 8'h89;
  // field positions of system_configuration
  localparam int unsigned F_XPERIPH_SHARING = 0;
  localparam int unsigned F_INTERNAL_ACCESS_A = 1;
  localparam int unsigned F_XBUS_PERIPH_ENABLE = 2;
  localparam int unsigned F_BIDIR_RESET_ENABLE = 3;
  localparam int unsigned F_OSC_WATCHDOG_DISABLE = 4;
  localparam int unsigned F_POWERDOWN_CONFIG = 5;
  localparam int unsigned F_CHIPSEL_TIMING_CONFIG = 6;
  localparam int unsigned F_WRITE_CONFIG = 7;
  localparam int unsigned F_CLOCK_OUTPUT_ENABLE = 8;
  localparam int unsigned F_BYTE_HIGH_DISABLE = 9;
  localparam int unsigned F_ROM_ENABLE_BIT = 10;
  localparam int unsigned F_SEGMENTATION_DISABLE = 11;
  localparam int unsigned F_ROM_SEGMENT_MAP = 12;
  localparam int unsigned F_STACK_SIZE_LO = 13;
  // reset value: fixed part plus bits taken from the strap pins
  localparam logic [15:0] CFG_RESET_FIXED = 16'h0000;
  localparam logic [15:0] CFG_STRAP_MASK = 16'h0680;
  // command register bits
  localparam int unsigned CMD_END_OF_INIT = 0;
  localparam int unsigned CMD_POWERDOWN = 1;
  localparam int unsigned CMD_SOFT_RESET = 2;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : scr_pkg

// file: verilog/scr_sysconf.sv
// system configuration register with axi4-lite access and its control logic
`timescale 1ns/1ps
// Functional notes
// - 16-bit register, read/write, individual bits settable and clearable by software.
// - reset value follows strap pins; low and high nibbles are zero.
// - rom enable, byte high disable, write config load from straps at reset.
// - after end-of-init the register can no longer be changed by software, except by the soft reset command, which reloads straps and unlocks it.
// - xbus peripheral enable 0 blocks xbus peripheral access, 1 allows it.
// - bidir reset enable 0: reset pin input only, internal resets leave it.
// - bidir reset enable 1: reset pin pulled low 1024 half-periods per internal reset.
// - watchdog on, pll bypassed: 1 us crystal silence switches to pll base.
// - watchdog off, pll bypassed: crystal clock used unless fallback already set, pll powered off.
// - powerdown config 0: powerdown entered only while nmi pin is low.
// - powerdown config 1: enter only if all enabled fast irq pins inactive.
// - powerdown config 1: any enabled fast irq pin asserted ends powerdown.
// - chip select config 0: chip selects change one clock period after ale rise.
// - chip select config 1: chip selects change with the ale rising edge.
// - end-of-init drives reset output pin high and locks the register.
module scr_sysconf
  import scr_pkg::*;
#(
  parameter int unsigned NIRQ = 4,
  parameter int unsigned CSW = 5
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [17:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [17:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] boot_config_port,
  input wire logic ext_access_pin,
  input wire logic wdt_reset_req,
  input wire logic pll_bypass,
  input wire logic crystal_input,
  input wire logic nmi_pin,
  input wire logic [NIRQ-1:0] fast_ext_irq_pins,
  input wire logic [NIRQ-1:0] fast_irq_enable,
  input wire logic ale,
  input wire logic [CSW-1:0] cs_decode,
  input wire logic xbus_req,
  output logic xbus_grant,
  output logic reset_input_pin_out,
  output logic reset_input_pin_oe,
  output logic reset_output_pin_n,
  output logic clock_fallback,
  output logic pll_power_off,
  output logic powerdown,
  output logic [CSW-1:0] chip_select_lines,
  output logic [15:0] system_configuration
);
  localparam int unsigned DRV_W = $clog2(RST_DRIVE_CYCLES + 1);
  localparam int unsigned OSC_WD_W = $clog2(OSC_WD_CYCLES + 1);
  localparam logic [DRV_W-1:0] DRV_LOAD = DRV_W'(RST_DRIVE_CYCLES);
  localparam logic [OSC_WD_W-1:0] OSC_WD_LAST = OSC_WD_W'(OSC_WD_CYCLES - 1);

  typedef struct packed {
    logic [15:0] cfg;
    logic locked;
    logic rst_out_n;
    logic [DRV_W-1:0] drv_cnt;
    logic rst_oe;
    logic pin_lvl;
    logic pd;
    logic [OSC_WD_W-1:0] oscwd_cnt;
    logic xtal_q;
    logic fallback;
    logic pll_off;
    logic ale_q;
    logic [CSW-1:0] cs_cap;
    logic cs_pend;
    logic [CSW-1:0] cs;
    logic xbus_grant;
    logic aw_got;
    logic [15:0] aw_idx;
    logic awready;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } scr_state_t;

  scr_state_t st_reg;
  scr_state_t st_next;
  scr_state_t st_rst;
  logic [15:0] strap_val;
  logic int_rst;
  logic ale_rise;
  logic [15:0] ar_idx;
  logic [15:0] wmask;

  // strap sampling: fixed zeros plus pins on the strapped fields
  always_comb begin
    strap_val = CFG_RESET_FIXED | (boot_config_port & CFG_STRAP_MASK);
    strap_val[F_ROM_ENABLE_BIT] = ext_access_pin;
    st_rst = '0;
    st_rst.cfg = strap_val;
    st_rst.awready = 1'b1;
    st_rst.wready = 1'b1;
    st_rst.arready = 1'b1;
    st_rst.xtal_q = crystal_input;
    st_rst.ale_q = ale;
  end

  assign ale_rise = ale & ~st_reg.ale_q;
  assign ar_idx = s_axi_araddr[17:2];

  always_comb begin
    st_next = st_reg;
    int_rst = 1'b0;
    wmask = {{8{st_reg.wstrb[1]}}, {8{st_reg.wstrb[0]}}};
    // write channel capture, either order
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.aw_got = 1'b1;
      st_next.aw_idx = s_axi_awaddr[17:2];
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.w_got = 1'b1;
      st_next.wdata = s_axi_wdata;
      st_next.wstrb = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = RESP_OKAY;
      unique case (st_reg.aw_idx)
        IDX_SYS_CONFIG: begin
          if (!st_reg.locked) begin
            st_next.cfg = (st_reg.cfg & ~wmask) | (st_reg.wdata[15:0] & wmask);
          end
        end
        IDX_BITMOD: begin
          if (!st_reg.locked) begin
            st_next.cfg = (st_reg.cfg & ~st_reg.wdata[31:16])
                | (st_reg.wdata[15:0] & st_reg.wdata[31:16]);
          end
        end
        IDX_CMD: begin
          if (st_reg.wdata[CMD_END_OF_INIT]) begin
            st_next.locked = 1'b1;
            st_next.rst_out_n = 1'b1;
          end
          if (st_reg.wdata[CMD_POWERDOWN] && !st_reg.pd) begin
            if (!st_reg.cfg[F_POWERDOWN_CONFIG]) begin
              st_next.pd = ~nmi_pin;
            end else begin
              st_next.pd = ~|(fast_ext_irq_pins & fast_irq_enable);
            end
          end
          int_rst = st_reg.wdata[CMD_SOFT_RESET];
        end
        default: st_next.bresp = RESP_SLVERR;
      endcase
    end
    // read channel
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_reg.arready) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = RESP_OKAY;
      unique case (ar_idx)
        IDX_SYS_CONFIG: st_next.rdata = {16'h0000, st_reg.cfg};
        IDX_BITMOD: st_next.rdata = 32'h0000_0000;
        IDX_CMD: st_next.rdata = {28'h000_0000, st_reg.rst_oe, st_reg.fallback,
                                  st_reg.pd, st_reg.locked};
        default: begin
          st_next.rdata = 32'h0000_0000;
          st_next.rresp = RESP_SLVERR;
        end
      endcase
    end
    st_next.awready = ~st_next.aw_got & ~st_next.bvalid;
    st_next.wready = ~st_next.w_got & ~st_next.bvalid;
    st_next.arready = ~st_next.rvalid;

    // powerdown exit by enabled fast interrupt
    if (st_reg.pd && st_reg.cfg[F_POWERDOWN_CONFIG]
        && |(fast_ext_irq_pins & fast_irq_enable)) begin
      st_next.pd = 1'b0;
    end

    // oscillator watchdog
    st_next.xtal_q = crystal_input;
    st_next.pll_off = st_reg.cfg[F_OSC_WATCHDOG_DISABLE] & pll_bypass;
    if (st_reg.cfg[F_OSC_WATCHDOG_DISABLE] || !pll_bypass
        || (crystal_input != st_reg.xtal_q)) begin
      st_next.oscwd_cnt = '0;
    end else if (!st_reg.fallback) begin
      if (st_reg.oscwd_cnt == OSC_WD_LAST) begin
        st_next.fallback = 1'b1;
      end else begin
        st_next.oscwd_cnt = st_reg.oscwd_cnt + OSC_WD_W'(1);
      end
    end

    // chip select timing relative to ale
    st_next.ale_q = ale;
    st_next.cs_pend = 1'b0;
    if (st_reg.cs_pend) begin
      st_next.cs = st_reg.cs_cap;
    end
    if (ale_rise) begin
      if (st_reg.cfg[F_CHIPSEL_TIMING_CONFIG]) begin
        st_next.cs = cs_decode;
      end else begin
        st_next.cs_cap = cs_decode;
        st_next.cs_pend = 1'b1;
      end
    end

    st_next.xbus_grant = xbus_req & st_reg.cfg[F_XBUS_PERIPH_ENABLE];

    // reset pin pull-low counter
    st_next.pin_lvl = 1'b0;
    if (st_reg.drv_cnt != '0) begin
      st_next.drv_cnt = st_reg.drv_cnt - DRV_W'(1);
    end

    // internal reset sequence: software or watchdog
    if (int_rst || wdt_reset_req) begin
      if (st_reg.cfg[F_BIDIR_RESET_ENABLE]) begin
        st_next.drv_cnt = DRV_LOAD;
      end
      st_next.cfg = strap_val;
      st_next.locked = 1'b0;
      st_next.rst_out_n = 1'b0;
      st_next.pd = 1'b0;
      st_next.fallback = 1'b0;
      st_next.oscwd_cnt = '0;
    end
    st_next.rst_oe = (st_next.drv_cnt != '0);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= st_rst;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign xbus_grant = st_reg.xbus_grant;
  assign reset_input_pin_out = st_reg.pin_lvl;
  assign reset_input_pin_oe = st_reg.rst_oe;
  assign reset_output_pin_n = st_reg.rst_out_n;
  assign clock_fallback = st_reg.fallback;
  assign pll_power_off = st_reg.pll_off;
  assign powerdown = st_reg.pd;
  assign chip_select_lines = st_reg.cs;
  assign system_configuration = st_reg.cfg;

  // length of the reset pin pull-low, counted for checking only
  logic [DRV_W:0] drv_run;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drv_run <= '0;
    end else if (st_reg.drv_cnt == DRV_LOAD) begin
      drv_run <= (DRV_W+1)'(1);
    end else if (st_reg.rst_oe) begin
      drv_run <= drv_run + (DRV_W+1)'(1);
    end
  end

  chk_reset_strap: assert property (@(posedge aclk) !aresetn |=>
      st_reg.cfg[3:0] == 4'h0 && st_reg.cfg[15:12] == 4'h0
      && st_reg.cfg[F_ROM_ENABLE_BIT] == $past(ext_access_pin))
    else $error("reset value does not follow straps");
  chk_lock_holds: assert property (@(posedge aclk) disable iff (!aresetn)
      st_reg.locked && !int_rst && !wdt_reset_req |=> st_reg.cfg == $past(st_reg.cfg))
    else $error("configuration changed after lock");
  chk_eoi_release: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(st_reg.locked) |-> st_reg.rst_out_n)
    else $error("lock without reset output release");
  chk_xbus_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      !st_reg.cfg[F_XBUS_PERIPH_ENABLE] |=> !st_reg.xbus_grant)
    else $error("xbus access while disabled");
  chk_pin_input_only: assert property (@(posedge aclk) disable iff (!aresetn)
      !st_reg.rst_oe && !st_reg.cfg[F_BIDIR_RESET_ENABLE] |=> !st_reg.rst_oe)
    else $error("reset pin driven while input only");
  chk_drive_length: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(st_reg.rst_oe) |-> drv_run == (DRV_W+1)'(RST_DRIVE_CYCLES))
    else $error("reset pin pull-low length wrong");
  chk_osc_fallback: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(st_reg.fallback) |-> $past(st_reg.oscwd_cnt) == OSC_WD_LAST && $past(pll_bypass))
    else $error("clock fallback without timeout");
  chk_osc_wd_off: assert property (@(posedge aclk) disable iff (!aresetn)
      st_reg.cfg[F_OSC_WATCHDOG_DISABLE] && pll_bypass
      |=> st_reg.pll_off && !$rose(st_reg.fallback))
    else $error("pll not off with watchdog disabled");
  chk_pd_nmi: assert property (@(posedge aclk) disable iff (!aresetn)
      !st_reg.pd && nmi_pin && !st_reg.cfg[F_POWERDOWN_CONFIG] |=> !st_reg.pd)
    else $error("powerdown entered with nmi high");
  chk_pd_wake: assert property (@(posedge aclk) disable iff (!aresetn)
      st_reg.pd && st_reg.cfg[F_POWERDOWN_CONFIG] && |(fast_ext_irq_pins & fast_irq_enable)
      |=> !st_reg.pd)
    else $error("powerdown not left on fast interrupt");
  chk_cs_latched: assert property (@(posedge aclk) disable iff (!aresetn)
      ale_rise && !st_reg.cfg[F_CHIPSEL_TIMING_CONFIG] |-> ##2 st_reg.cs == $past(cs_decode, 2))
    else $error("latched chip select timing wrong");
  chk_cs_unlatched: assert property (@(posedge aclk) disable iff (!aresetn)
      ale_rise && st_reg.cfg[F_CHIPSEL_TIMING_CONFIG] |=> st_reg.cs == $past(cs_decode))
    else $error("unlatched chip select timing wrong");
endmodule : scr_sysconf

// file: test/system_config_register_bench.sv
// self-checking bench for the system configuration register block
`timescale 1ns/1ps
module system_config_register_bench;
  import scr_pkg::*;
  logic aclk = '0, aresetn = '0, awv = '0, wv = '0, bb = '0, arv = '0, rr = '0, eap = '0;
  logic wdt = '0, byp = '0, xt = '0, nmi = '1, ale = '0, xrq = '0, xrun = '0;
  logic awr, wr, bv, arr, rv, grant, rpo, roe, rop_n, fb, ppo, pd;
  logic [17:0] aw = '0, ar = '0;
  logic [31:0] wd = '0, rd, v;
  logic [3:0] ws = '0, irq = '0, ien = '0;
  logic [15:0] bcp = '0, sc;
  logic [4:0] csd = '0, cs, cs_exp = '0;
  logic [1:0] br, rp, resp;
  int num_errors = 0, checks = 0, cycles = 0, exp_cfg;
  logic [31:0] n;

  scr_sysconf scr_sysconf_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bb), .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .boot_config_port(bcp), .ext_access_pin(eap), .wdt_reset_req(wdt), .pll_bypass(byp),
    .crystal_input(xt), .nmi_pin(nmi), .fast_ext_irq_pins(irq), .fast_irq_enable(ien),
    .ale(ale), .cs_decode(csd), .xbus_req(xrq), .xbus_grant(grant),
    .reset_input_pin_out(rpo), .reset_input_pin_oe(roe), .reset_output_pin_n(rop_n),
    .clock_fallback(fb), .pll_power_off(ppo), .powerdown(pd), .chip_select_lines(cs),
    .system_configuration(sc));

  function automatic int strap();
    return {21'h0, eap, bcp[9], 1'h0, bcp[7], 7'h0};
  endfunction : strap

  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  task automatic wr_reg(logic [15:0] idx, logic [31:0] d, logic [3:0] s);
    aw <= {idx, 2'h0};
    wd <= d;
    ws <= s;
    awv <= '1;
    wv <= '1;
    bb <= '1;
    do begin
      @(posedge aclk);
      if (awv && awr) awv <= '0;
      if (wv && wr) wv <= '0;
    end while (!(bv && bb));
    resp = br;
    bb <= '0;
    @(posedge aclk);
  endtask : wr_reg

  task automatic rcheck(string what, logic [15:0] idx, logic [31:0] exp, logic [1:0] er);
    ar <= {idx, 2'h0};
    arv <= '1;
    rr <= '1;
    do begin
      @(posedge aclk);
      if (arv && arr) arv <= '0;
    end while (!(rv && rr));
    chk(what, rd, exp);
    chk("read resp", 32'(rp), 32'(er));
    rr <= '0;
    @(posedge aclk);
  endtask : rcheck

  task automatic count_drive(int e);
    n = 0;
    repeat (600) begin
      @(posedge aclk);
      n += 32'(roe);
    end
    chk("reset pin drive", n, e);
    chk("reset pin level", 32'(rpo), 0);
    chk("reset out low", 32'(rop_n), 0);
  endtask : count_drive

  initial begin
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (xrun) xt <= ~xt;
    cycles++;
    if (cycles == 10000) begin
      num_errors++;
      conclude();
    end
  end

  initial begin
    v = $urandom(32'h9ce5_c275);
    bcp <= 16'($urandom());
    eap <= 1'($urandom());
    ien <= 4'h5;
    repeat (20) @(posedge aclk);
    aresetn <= '1;
    @(posedge aclk);
    exp_cfg = strap();
    chk("reset value", 32'(sc), exp_cfg);
    rcheck("cfg read", IDX_SYS_CONFIG, exp_cfg, RESP_OKAY);
    $display("test reset done");
    for (int i = 1; i < 4; i++) begin
      v = $urandom();
      wr_reg(IDX_SYS_CONFIG, v, 4'(i));
      if (i[0]) exp_cfg[7:0] = v[7:0];
      if (i[1]) exp_cfg[15:8] = v[15:8];
      chk("write resp", 32'(resp), 32'(RESP_OKAY));
      rcheck("cfg readback", IDX_SYS_CONFIG, exp_cfg, RESP_OKAY);
    end
    xrq <= '1;
    for (int b = 0; b < 2; b++) begin
      wr_reg(IDX_BITMOD, {16'h0004, 16'(b << 2)}, 4'hf);
      exp_cfg[2] = b[0];
      rcheck("bit modify", IDX_SYS_CONFIG, exp_cfg, RESP_OKAY);
      chk("xbus grant", 32'(grant), b);
    end
    wr_reg(16'h0100, 32'hffff_ffff, 4'hf);
    chk("unmapped write", 32'(resp), 32'(RESP_SLVERR));
    rcheck("unmapped read", 16'h0100, 32'h0, RESP_SLVERR);
    rcheck("cfg kept", IDX_SYS_CONFIG, exp_cfg, RESP_OKAY);
    $display("test access done");
    for (int c = 0; c < 2; c++) begin
      wr_reg(IDX_BITMOD, {16'h0040, 16'(c << 6)}, 4'hf);
      v = 32'(~cs_exp);
      csd <= v[4:0];
      ale <= '1;
      @(posedge aclk);
      csd <= ~v[4:0];
      @(posedge aclk);
      chk("cs at ale rise", 32'(cs), 32'(c ? v[4:0] : cs_exp));
      @(posedge aclk);
      chk("cs settled", 32'(cs), 32'(v[4:0]));
      ale <= '0;
      cs_exp = v[4:0];
    end
    $display("test chip select done");
    wr_reg(IDX_BITMOD, 32'h0010_0000, 4'hf);
    byp <= '1;
    xrun <= '1;
    repeat (150) @(posedge aclk);
    chk("no fallback", 32'({fb, ppo}), 0);
    xrun <= '0;
    repeat (110) @(posedge aclk);
    chk("fallback", 32'(fb), 1);
    wr_reg(IDX_BITMOD, 32'h0010_0010, 4'hf);
    chk("pll off", 32'(ppo), 1);
    byp <= '0;
    $display("test osc watchdog done");
    wr_reg(IDX_BITMOD, 32'h0028_0008, 4'hf);
    wr_reg(IDX_CMD, 32'h2, 4'hf);
    chk("pd nmi high", 32'(pd), 0);
    nmi <= '0;
    wr_reg(IDX_CMD, 32'h2, 4'hf);
    chk("pd nmi low", 32'(pd), 1);
    aresetn <= '0;
    repeat (2) @(posedge aclk);
    aresetn <= '1;
    @(posedge aclk);
    chk("pd after ext reset", 32'(pd), 0);
    chk("cfg after ext reset", 32'(sc), strap());
    wr_reg(IDX_BITMOD, 32'h0008_0008, 4'hf);
    wr_reg(IDX_CMD, 32'h2, 4'hf);
    chk("pd again", 32'(pd), 1);
    bcp <= 16'($urandom());
    wdt <= '1;
    @(posedge aclk);
    wdt <= '0;
    nmi <= '1;
    count_drive(RST_DRIVE_CYCLES);
    chk("pd after reset", 32'(pd), 0);
    chk("cfg reload", 32'(sc), strap());
    $display("test internal reset done");
    wr_reg(IDX_BITMOD, 32'h0020_0020, 4'hf);
    irq <= 4'h1;
    wr_reg(IDX_CMD, 32'h2, 4'hf);
    chk("pd irq active", 32'(pd), 0);
    irq <= 4'h2;
    wr_reg(IDX_CMD, 32'h2, 4'hf);
    chk("pd masked irq", 32'(pd), 1);
    irq <= 4'h6;
    repeat (3) @(posedge aclk);
    chk("pd wake", 32'(pd), 0);
    irq <= '0;
    wr_reg(IDX_CMD, 32'h4, 4'hf);
    count_drive(0);
    $display("test powerdown done");
    wr_reg(IDX_CMD, 32'h1, 4'hf);
    chk("reset out high", 32'(rop_n), 1);
    wr_reg(IDX_SYS_CONFIG, ~32'(strap()), 4'hf);
    chk("locked write", 32'(resp), 32'(RESP_OKAY));
    wr_reg(IDX_BITMOD, 32'hffff_ffff, 4'hf);
    rcheck("locked cfg", IDX_SYS_CONFIG, strap(), RESP_OKAY);
    rcheck("lock status", IDX_CMD, 32'h1, RESP_OKAY);
    $display("test lock done");
    conclude();
  end
endmodule : system_config_register_bench
